// ===== stlc_cfg_capture.sv
// Capture of link parameters sent by the transmitter on lane 0.
// Assumes the lane 0 decoder gives one valid pulse per configuration set.
`timescale 1ns/10ps
module stlc_cfg_capture
    import stlc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               cfg_valid,
    input  wire logic [OCTET_W-1:0] cfg_octet0,
    input  wire logic [OCTET_W-1:0] cfg_octet1,
    input  wire logic [OCTET_W-1:0] cfg_octet2,
    output logic      [DATA_W-1:0]  device_id_r,
    output logic      [DATA_W-1:0]  bank_adjust_r,
    output logic      [DATA_W-1:0]  lane_identity_r
);

    // ******************************************************************
    // Capture registers
    // ******************************************************************
    // Held between alignment sequences so reads never see a torn set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            device_id_r     <= RST_CAPTURED;
            bank_adjust_r   <= RST_CAPTURED;
            lane_identity_r <= RST_CAPTURED;
        end else if (cfg_valid) begin
            device_id_r     <= cfg_octet0;
            bank_adjust_r   <= {cfg_octet1[ADJ_RES_LSB +: ADJ_RES_W],
                                cfg_octet1[BANK_LSB +: BANK_W]};
            lane_identity_r <= {1'b0,
                                cfg_octet2[ADJ_DIR_BIT],
                                cfg_octet2[PHASE_ADJ_BIT],
                                cfg_octet2[LANE_ID_LSB +: LANE_ID_W]};
        end
    end

endmodule : stlc_cfg_capture

// ===== stlc_chk.sv
// Checker for the link test and lane information block.
// Sees only stlc_top ports; bound into every stlc_top instance.
`timescale 1ns/10ps
module stlc_chk
    import stlc_pkg::*;
#(
    parameter int NLANES = NUM_LANES,
    parameter int NCONV  = NUM_CONV,
    parameter int NSAMP  = SAMP_PER_CNV
) (
    input wire logic                            clk,
    input wire logic                            rstn,
    input wire logic [ADDR_W-1:0]               reg_addr,
    input wire logic                            reg_wr,
    input wire logic [DATA_W-1:0]               reg_wdata,
    input wire logic                            reg_rd,
    input wire logic [DATA_W-1:0]               reg_rdata,
    input wire logic                            reg_rvalid,
    input wire logic                            lane_valid_in,
    input wire logic [NLANES*OCTET_W-1:0]       lane_data_in,
    input wire logic [NLANES*OCTET_W-1:0]       lane_data_out,
    input wire logic                            sample_valid,
    input wire logic [NCONV*NSAMP*SAMPLE_W-1:0] sample_data,
    input wire logic [DATA_W-1:0]               link_required_config,
    input wire logic                            link_config_valid,
    input wire logic                            test_fail_flag
);
    // ****************************************
    // Shadow registers
    // ****************************************
    logic [7:0]                  ctl_r, lo_r, hi_r, mask_r;
    logic [NLANES*OCTET_W-1:0]   inv;
    logic [SAMPLE_W-1:0]         sel;
    logic                        hit, clr;

    // Mirror the writes so checks do not depend on readback
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r  <= 8'h00;
            lo_r   <= 8'h00;
            hi_r   <= 8'h00;
            mask_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == OFF_TPL_TEST_CONTROL) ctl_r <= reg_wdata;
            if (reg_addr == OFF_TPL_REF_LOW) lo_r <= reg_wdata;
            if (reg_addr == OFF_TPL_REF_HIGH) hi_r <= reg_wdata;
            if (reg_addr == OFF_LANE_INVERT_MASK) mask_r <= reg_wdata;
        end
    end

    // Selected slot, mismatch and clear conditions
    always_comb begin
        for (int i = 0; i < NLANES; i++) inv[8*i+:8] = {8{mask_r[i]}};
        sel = sample_data[SAMPLE_W*(int'(ctl_r[3])*NSAMP+int'(ctl_r[5:4]))+:SAMPLE_W];
        hit = sample_valid && ctl_r[0] && (sel != {hi_r, lo_r});
        clr = reg_wr && (reg_addr == OFF_TPL_TEST_CONTROL) && reg_wdata[1];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_read_answer: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_lane_invert: assert property (lane_valid_in |=>
        lane_data_out == ($past(lane_data_in) ^ $past(inv)))
        else $error("lane data not inverted by mask");
    chk_lane_hold: assert property (!lane_valid_in |=> $stable(lane_data_out))
        else $error("lane data moved without valid");
    chk_cfg_level: assert property (link_config_valid == (link_required_config == 8'h01))
        else $error("config valid does not follow byte");
    chk_cfg_write: assert property (reg_wr && reg_addr == OFF_LINK_REQ_CONFIG |=>
        link_required_config == $past(reg_wdata))
        else $error("required config byte not stored");
    chk_fail_set: assert property (hit |=> test_fail_flag)
        else $error("mismatch did not set fail flag");
    chk_fail_clear: assert property (clr && !hit |=> !test_fail_flag)
        else $error("clear did not drop fail flag");
    chk_fail_hold: assert property (!hit && !clr |=> $stable(test_fail_flag))
        else $error("fail flag moved without cause");
endmodule : stlc_chk

bind stlc_top stlc_chk #(.NLANES(NLANES), .NCONV(NCONV), .NSAMP(NSAMP)) u_chk (.*);

// ===== stlc_pkg.sv
// Package for the link test and lane information block.
// Holds register offsets, field positions, reset values and data widths.
// Assumes a byte-wide register port with 12-bit addresses.
package stlc_pkg;

    // ******************************************************************
    // Data widths
    // ******************************************************************
    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 8;
    localparam int SAMPLE_W     = 16;
    localparam int OCTET_W      = 8;
    localparam int NUM_LANES    = 8;
    localparam int NUM_CONV     = 2;
    localparam int SAMP_PER_CNV = 4;

    // ******************************************************************
    // Register offsets
    // ******************************************************************
    localparam logic [11:0] OFF_TPL_TEST_CONTROL  = 12'h32C;
    localparam logic [11:0] OFF_TPL_REF_LOW       = 12'h32D;
    localparam logic [11:0] OFF_TPL_REF_HIGH      = 12'h32E;
    localparam logic [11:0] OFF_TPL_TEST_RESULT   = 12'h32F;
    localparam logic [11:0] OFF_LINK_REQ_CONFIG   = 12'h333;
    localparam logic [11:0] OFF_LANE_INVERT_MASK  = 12'h334;
    localparam logic [11:0] OFF_RX_DEVICE_ID      = 12'h400;
    localparam logic [11:0] OFF_RX_BANK_ADJUST    = 12'h401;
    localparam logic [11:0] OFF_RX_LANE0_IDENTITY = 12'h402;

    // ******************************************************************
    // Field positions of the test control and test result registers
    // ******************************************************************
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_CLEAR_BIT  = 1;
    localparam int CTL_CHAN_LSB   = 2;
    localparam int CTL_SAMPLE_LSB = 4;
    localparam int FIELD2_W       = 2;
    localparam int RESULT_FAIL_BIT = 0;

    // Field positions inside the captured lane 0 configuration octets
    localparam int BANK_LSB       = 0;
    localparam int BANK_W         = 4;
    localparam int ADJ_RES_LSB    = 4;
    localparam int ADJ_RES_W      = 4;
    localparam int LANE_ID_LSB    = 0;
    localparam int LANE_ID_W      = 5;
    localparam int PHASE_ADJ_BIT  = 5;
    localparam int ADJ_DIR_BIT    = 6;

    // ******************************************************************
    // Reset values
    // ******************************************************************
    localparam logic [7:0] RST_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_REF_BYTE     = 8'h00;
    localparam logic [7:0] RST_REQ_CONFIG   = 8'h00;
    localparam logic [7:0] RST_INVERT_MASK  = 8'h00;
    localparam logic [7:0] RST_CAPTURED     = 8'h00;
    localparam logic [7:0] REQ_CONFIG_VALUE = 8'h01;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // Address match, shared by the write decode and the read mux
    function automatic logic stlc_hit(input logic [11:0] addr, input logic [11:0] off);
        stlc_hit = (addr == off);
    endfunction : stlc_hit

endpackage : stlc_pkg

// ===== stlc_tb_top.sv
// Self-checking bench for the link test and lane information block.
// Drives the register port directly and the far side through the model.
`timescale 1ns/10ps
module stlc_tb_top;
    import stlc_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, reg_rvalid, lane_valid_in, lane_valid_out;
    logic sample_valid, cfg_valid, link_config_valid, test_fail_flag;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, link_required_config, cfg_octet0, cfg_octet1;
    logic [7:0] cfg_octet2, m, ctl, v;
    logic [63:0] lane_data_in, lane_data_out, d;
    logic [127:0] sample_data, s;
    logic [15:0] r;
    logic [31:0] c;
    int n_mismatch = 0, check_count = 0, seed = 56;
    logic [11:0] all_a [10] = '{12'h32C, 12'h32D, 12'h32E, 12'h32F, 12'h333,
                                12'h334, 12'h400, 12'h401, 12'h402, 12'h335};

    stlc_top dut (.*);
    stlc_tx_model tx (.*);

    // ****************************************
    // Clock, tasks and expectations
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp64
    // Strobe one cycle, then one idle edge so strobes never merge
    task automatic wr(input logic [11:0] a, input logic [7:0] dt);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, dt};
        @(posedge clk); #1;
        reg_wr = 1'b0;
        @(posedge clk); #1;
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk); #1;
        reg_rd = 1'b0;
        cmp8({7'h0, reg_rvalid}, 8'h01);
        cmp8(reg_rdata, exp);
        @(posedge clk); #1;
    endtask : rchk
    function automatic logic [63:0] flane(input logic [63:0] x, input logic [7:0] k);
        for (int i = 0; i < NUM_LANES; i++) x[8*i+:8] = x[8*i+:8] ^ {8{k[i]}};
        return x;
    endfunction : flane
    function automatic int fslot(input logic [7:0] k);
        return int'(k[3]) * SAMP_PER_CNV + int'(k[5:4]);
    endfunction : fslot
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Watchdog, far above the roughly 450 cycles the tests need
    initial begin
        #(100 * 20000);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        foreach (all_a[i]) rchk(all_a[i], 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(all_a[i+1 + (i/2)*2], v);
            rchk(all_a[i+1 + (i/2)*2], i == 3 ? 8'h00 : v);
        end
        wr(OFF_TPL_TEST_CONTROL, 8'hFF);
        rchk(OFF_TPL_TEST_CONTROL, 8'h3F);
        for (int i = 6; i < 9; i++) wr(all_a[i], 8'hA5);
        for (int i = 6; i < 9; i++) rchk(all_a[i], 8'h00);
        wr(OFF_LINK_REQ_CONFIG, REQ_CONFIG_VALUE);
        cmp8({7'h0, link_config_valid}, 8'h01);
        cmp8(link_required_config, 8'h01);
        wr(OFF_LINK_REQ_CONFIG, 8'h02);
        cmp8({7'h0, link_config_valid}, 8'h00);
        // Lane inversion with empty, full and random masks
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            wr(OFF_LANE_INVERT_MASK, m);
            d = {32'($random(seed)), 32'($random(seed))};
            tx.send_lanes(d);
            cmp64(lane_data_out, flane(d, m));
            cmp8({7'h0, lane_valid_out}, 8'h00);
        end
        // Every channel code and sample index; wrong slot would flip result
        for (int k = 0; k < 16; k++) begin
            r = 16'($random(seed));
            ctl = {2'b00, 4'(k), 2'b01};
            wr(OFF_TPL_REF_LOW, r[7:0]);
            wr(OFF_TPL_REF_HIGH, r[15:8]);
            wr(OFF_TPL_TEST_CONTROL, ctl | 8'h02);
            rchk(OFF_TPL_TEST_RESULT, 8'h00);
            s = ~{8{r}};
            s[16*fslot(ctl)+:16] = r;
            tx.send_samples(s);
            rchk(OFF_TPL_TEST_RESULT, 8'h00);
            s = {8{r}};
            s[16*fslot(ctl)+:16] = r ^ (16'h1 << k);
            tx.send_samples(s);
            rchk(OFF_TPL_TEST_RESULT, 8'h01);
            cmp8({7'h0, test_fail_flag}, 8'h01);
            wr(OFF_TPL_TEST_CONTROL, ctl ^ 8'h03);
            tx.send_samples(s);
            rchk(OFF_TPL_TEST_RESULT, 8'h00);
        end
        // Lane 0 config: clean, then a transmitter breaking zero fields
        for (int k = 0; k < 2; k++) begin
            c = 32'($random(seed)) | 32'h0100_0000;
            tx.send_cfg(c, k[0]);
            rchk(OFF_RX_DEVICE_ID, c[7:0]);
            rchk(OFF_RX_BANK_ADJUST, {k[0] ? c[27:24] : 4'h0, c[11:8]});
            rchk(OFF_RX_LANE0_IDENTITY, {1'b0, {2{k[0]}}, c[20:16]});
        end
        tx.send_lanes(d);
        rchk(OFF_RX_DEVICE_ID, c[7:0]);
        print_verdict();
    end
endmodule : stlc_tb_top

// ===== stlc_top.sv
// Receive-side test and status logic of the serial link receiver.
// Assumes the register port, lane data and samples all run on clk.
`timescale 1ns/10ps
module stlc_top
    import stlc_pkg::*;
#(
    parameter int NLANES = NUM_LANES,
    parameter int NCONV  = NUM_CONV,
    parameter int NSAMP  = SAMP_PER_CNV
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // Register port
    input  wire logic [ADDR_W-1:0]               reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic [DATA_W-1:0]               reg_wdata,
    input  wire logic                            reg_rd,
    output logic      [DATA_W-1:0]               reg_rdata,
    output logic                                 reg_rvalid,
    // Deserialized lane data
    input  wire logic                            lane_valid_in,
    input  wire logic [NLANES*OCTET_W-1:0]       lane_data_in,
    output logic                                 lane_valid_out,
    output logic      [NLANES*OCTET_W-1:0]       lane_data_out,
    // Samples at the receiver output
    input  wire logic                            sample_valid,
    input  wire logic [NCONV*NSAMP*SAMPLE_W-1:0] sample_data,
    // Lane 0 configuration octets from the alignment sequence
    input  wire logic                            cfg_valid,
    input  wire logic [OCTET_W-1:0]              cfg_octet0,
    input  wire logic [OCTET_W-1:0]              cfg_octet1,
    input  wire logic [OCTET_W-1:0]              cfg_octet2,
    // Status toward the rest of the link logic
    output logic      [DATA_W-1:0]               link_required_config,
    output logic                                 link_config_valid,
    output logic                                 test_fail_flag
);

    // ******************************************************************
    // Register storage
    // ******************************************************************
    logic [DATA_W-1:0] tpl_test_control_r;
    logic [DATA_W-1:0] tpl_reference_low_r;
    logic [DATA_W-1:0] tpl_reference_high_r;
    logic [DATA_W-1:0] link_required_config_r;
    logic [DATA_W-1:0] lane_invert_mask_r;
    logic [DATA_W-1:0] rx_device_identifier;
    logic [DATA_W-1:0] rx_bank_and_adjust;
    logic [DATA_W-1:0] rx_lane0_identity;
    logic [DATA_W-1:0] reg_rdata_r;
    logic [DATA_W-1:0] reg_rdata_nxt;
    logic              reg_rvalid_r;
    logic              fail_r;

    // ******************************************************************
    // Write decode
    // ******************************************************************
    logic wr_control;
    logic wr_ref_low;
    logic wr_ref_high;
    logic wr_req_cfg;
    logic wr_inv_mask;
    logic clear_pulse;

    // Writes to read-only or unmapped offsets fall through and are dropped
    always_comb begin
        wr_control  = reg_wr && stlc_hit(reg_addr, OFF_TPL_TEST_CONTROL);
        wr_ref_low  = reg_wr && stlc_hit(reg_addr, OFF_TPL_REF_LOW);
        wr_ref_high = reg_wr && stlc_hit(reg_addr, OFF_TPL_REF_HIGH);
        wr_req_cfg  = reg_wr && stlc_hit(reg_addr, OFF_LINK_REQ_CONFIG);
        wr_inv_mask = reg_wr && stlc_hit(reg_addr, OFF_LANE_INVERT_MASK);
    end

    // Clear acts on the write itself; a stored one does not keep clearing
    assign clear_pulse = wr_control && reg_wdata[CTL_CLEAR_BIT];

    // ******************************************************************
    // Test control register
    // ******************************************************************
    // Top two bits are reserved and always stored as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tpl_test_control_r <= RST_TEST_CONTROL;
        end else if (wr_control) begin
            tpl_test_control_r <= {2'b00, reg_wdata[5:0]};
        end
    end

    // ******************************************************************
    // Reference sample bytes
    // ******************************************************************
    // Low byte register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tpl_reference_low_r <= RST_REF_BYTE;
        end else if (wr_ref_low) begin
            tpl_reference_low_r <= reg_wdata;
        end
    end

    // High byte register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tpl_reference_high_r <= RST_REF_BYTE;
        end else if (wr_ref_high) begin
            tpl_reference_high_r <= reg_wdata;
        end
    end

    // ******************************************************************
    // Required configuration byte
    // ******************************************************************
    // Kept as written; the link logic downstream trusts software for the value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_required_config_r <= RST_REQ_CONFIG;
        end else if (wr_req_cfg) begin
            link_required_config_r <= reg_wdata;
        end
    end

    // Flag for the link logic that the byte holds the one proper value
    assign link_required_config = link_required_config_r;
    assign link_config_valid    = (link_required_config_r == REQ_CONFIG_VALUE);

    // ******************************************************************
    // Lane inversion mask
    // ******************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lane_invert_mask_r <= RST_INVERT_MASK;
        end else if (wr_inv_mask) begin
            lane_invert_mask_r <= reg_wdata;
        end
    end

    // ******************************************************************
    // Lane data path
    // ******************************************************************
    // One register stage; mask changes apply from the next octet onward
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lane_data_out <= '0;
        end else if (lane_valid_in) begin
            for (int i = 0; i < NLANES; i++) begin
                lane_data_out[i*OCTET_W +: OCTET_W] <=
                    lane_data_in[i*OCTET_W +: OCTET_W] ^ {OCTET_W{lane_invert_mask_r[i]}};
            end
        end
    end

    // Valid follows the data by the same single stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lane_valid_out <= 1'b0;
        end else begin
            lane_valid_out <= lane_valid_in;
        end
    end

    // ******************************************************************
    // Short transport layer checker
    // ******************************************************************
    stlc_tpl_check #(
        .NCONV (NCONV),
        .NSAMP (NSAMP)
    ) u_tpl_check (
        .clk                 (clk),
        .rstn                (rstn),
        .test_enable_bit     (tpl_test_control_r[CTL_ENABLE_BIT]),
        .clear_pulse         (clear_pulse),
        .reference           ({tpl_reference_high_r, tpl_reference_low_r}),
        .test_channel_select (tpl_test_control_r[CTL_CHAN_LSB +: FIELD2_W]),
        .test_sample_index   (tpl_test_control_r[CTL_SAMPLE_LSB +: FIELD2_W]),
        .sample_valid        (sample_valid),
        .sample_data         (sample_data),
        .test_fail_flag      (fail_r)
    );

    assign test_fail_flag = fail_r;

    // ******************************************************************
    // Lane 0 configuration capture
    // ******************************************************************
    stlc_cfg_capture u_cfg_capture (
        .clk             (clk),
        .rstn            (rstn),
        .cfg_valid       (cfg_valid),
        .cfg_octet0      (cfg_octet0),
        .cfg_octet1      (cfg_octet1),
        .cfg_octet2      (cfg_octet2),
        .device_id_r     (rx_device_identifier),
        .bank_adjust_r   (rx_bank_and_adjust),
        .lane_identity_r (rx_lane0_identity)
    );

    // ******************************************************************
    // Read mux
    // ******************************************************************
    // Unmapped offsets read as zero so a stray read is harmless
    always_comb begin
        reg_rdata_nxt = READ_ZERO;
        if (stlc_hit(reg_addr, OFF_TPL_TEST_CONTROL)) begin
            reg_rdata_nxt = tpl_test_control_r;
        end else if (stlc_hit(reg_addr, OFF_TPL_REF_LOW)) begin
            reg_rdata_nxt = tpl_reference_low_r;
        end else if (stlc_hit(reg_addr, OFF_TPL_REF_HIGH)) begin
            reg_rdata_nxt = tpl_reference_high_r;
        end else if (stlc_hit(reg_addr, OFF_TPL_TEST_RESULT)) begin
            reg_rdata_nxt = {7'h00, fail_r};
        end else if (stlc_hit(reg_addr, OFF_LINK_REQ_CONFIG)) begin
            reg_rdata_nxt = link_required_config_r;
        end else if (stlc_hit(reg_addr, OFF_LANE_INVERT_MASK)) begin
            reg_rdata_nxt = lane_invert_mask_r;
        end else if (stlc_hit(reg_addr, OFF_RX_DEVICE_ID)) begin
            reg_rdata_nxt = rx_device_identifier;
        end else if (stlc_hit(reg_addr, OFF_RX_BANK_ADJUST)) begin
            reg_rdata_nxt = rx_bank_and_adjust;
        end else if (stlc_hit(reg_addr, OFF_RX_LANE0_IDENTITY)) begin
            reg_rdata_nxt = rx_lane0_identity;
        end
    end

    // Read data is registered; it holds until the next read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_r <= READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // One-cycle pulse marking the read answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
        end
    end

    assign reg_rdata  = reg_rdata_r;
    assign reg_rvalid = reg_rvalid_r;

endmodule : stlc_top

// ===== stlc_tpl_check.sv
// Short transport layer checker: compares one received sample with a reference.
// Assumes samples arrive on the same clock, already unpacked by the receiver.
`timescale 1ns/10ps
module stlc_tpl_check
    import stlc_pkg::*;
#(
    parameter int NCONV = NUM_CONV,
    parameter int NSAMP = SAMP_PER_CNV
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            test_enable_bit,
    input  wire logic                            clear_pulse,
    input  wire logic [SAMPLE_W-1:0]             reference,
    input  wire logic [1:0]                      test_channel_select,
    input  wire logic [1:0]                      test_sample_index,
    input  wire logic                            sample_valid,
    input  wire logic [NCONV*NSAMP*SAMPLE_W-1:0] sample_data,
    output logic                                 test_fail_flag
);

    // ******************************************************************
    // Sample selection
    // ******************************************************************
    int                  conv_idx;
    int                  slot_idx;
    logic [SAMPLE_W-1:0] picked;
    logic                mismatch;

    // Channel code 0 is the first converter, 2 the second; bit 1 decides
    always_comb begin
        conv_idx = int'(test_channel_select[1]) % NCONV;
        slot_idx = conv_idx * NSAMP + (int'(test_sample_index) % NSAMP);
        picked   = sample_data[slot_idx*SAMPLE_W +: SAMPLE_W];
        mismatch = test_enable_bit && sample_valid && (picked != reference);
    end

    // ******************************************************************
    // Sticky result
    // ******************************************************************
    // A mismatch in the clearing cycle survives: set beats clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            test_fail_flag <= 1'b0;
        end else if (mismatch) begin
            test_fail_flag <= 1'b1;
        end else if (clear_pulse) begin
            test_fail_flag <= 1'b0;
        end
    end

endmodule : stlc_tpl_check

// ===== stlc_tx_model.sv
// Transmitter model: lane octets, receiver samples, lane 0 config.
// Tasks are called just after a rising edge of clk.
`timescale 1ns/10ps
module stlc_tx_model
    import stlc_pkg::*;
(
    input  wire logic                               clk,
    output logic                                    lane_valid_in,
    output logic [NUM_LANES*OCTET_W-1:0]            lane_data_in,
    output logic                                    sample_valid,
    output logic [NUM_CONV*SAMP_PER_CNV*SAMPLE_W-1:0] sample_data,
    output logic                                    cfg_valid,
    output logic [OCTET_W-1:0]                      cfg_octet0,
    output logic [OCTET_W-1:0]                      cfg_octet1,
    output logic [OCTET_W-1:0]                      cfg_octet2
);
    // ****************************************
    // Transfers
    // ****************************************
    // Released lines show inverted data so stale values never match
    initial begin
        {lane_valid_in, sample_valid, cfg_valid} = 3'h0;
        {lane_data_in, sample_data} = '0;
        {cfg_octet0, cfg_octet1, cfg_octet2} = 24'h0;
    end
    task automatic send_lanes(input logic [NUM_LANES*OCTET_W-1:0] d);
        lane_valid_in = 1'b1;
        lane_data_in = d;
        @(posedge clk); #1;
        lane_valid_in = 1'b0;
        lane_data_in = ~d;
        @(posedge clk); #1;
    endtask : send_lanes
    task automatic send_samples(input logic [NUM_CONV*SAMP_PER_CNV*SAMPLE_W-1:0] s);
        sample_valid = 1'b1;
        sample_data = s;
        @(posedge clk); #1;
        sample_valid = 1'b0;
        sample_data = ~s;
        @(posedge clk); #1;
    endtask : send_samples
    // Bad mode breaks the zero fields on purpose, only when asked
    task automatic send_cfg(input logic [31:0] c, input logic bad);
        cfg_valid = 1'b1;
        cfg_octet0 = c[7:0];
        cfg_octet1 = {bad ? c[27:24] : 4'h0, c[11:8]};
        cfg_octet2 = {bad ? 3'h7 : 3'h0, c[20:16]};
        @(posedge clk); #1;
        cfg_valid = 1'b0;
        {cfg_octet0, cfg_octet1, cfg_octet2} = ~{cfg_octet0, cfg_octet1, cfg_octet2};
        @(posedge clk); #1;
    endtask : send_cfg
endmodule : stlc_tx_model
